// >>> core/crystal_osc_ctrl.sv
// Summary of operation
// - The start-up counter advances only on ticks of the always-on slow oscillator.
// - A start delay field of n loads a start-up count of 2 to the n slow cycles, 1 to 32768.
// - After the count expires, three oscillator cycles pass before ready is set.
// - Ready reads one only while the oscillator is stable and usable, else zero.
// - The automatic amplitude control bit turns automatic gain adjustment on or off.
// - While automatic control is on, writes to the gain field change nothing applied.
// - With run on request set and enabled, the oscillator runs only while a clock is requested.
// - With run on request clear, an enabled oscillator runs regardless of requests.
// - With run in standby clear, the oscillator stops in standby sleep.
// - With run in standby set, standby keeps the same request or continuous behaviour.
// - Crystal select picks a crystal across both pads or an external clock on the input pad.
// - The enable bit turns the oscillator off at zero and on at one, subject to gating.
// - Reserved control bits 5:3 and 0 read zero and software writes them as zero.
// - A rising ready bit sets the sticky ready flag, which raises the interrupt when enabled.
`timescale 1ns/1ns
`default_nettype none
`include "crystal_osc_params.svh"

module crystal_osc_ctrl
    import crystal_osc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 16
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic write_protect,
    input wire logic slow_osc_tick,
    input wire logic crystal_osc_tick,
    input wire logic clock_request,
    input wire logic standby,
    output logic crystal_osc_run,
    output logic crystal_select,
    output logic output_pad_free,
    output logic auto_amplitude_control,
    output logic [2:0] osc_gain,
    output logic crystal_osc_ready,
    output logic [15:0] slow_crystal_osc_ctrl,
    output logic irq
);

    ctrl_t ctrl_reg;
    logic [15:0] slow_ctrl_reg;
    logic int_flag_reg;
    logic int_mask_reg;
    logic run_reg;
    logic [2:0] gain_reg;
    logic ready_q_reg;
    logic [31:0] prdata_reg;
    logic ready;
    logic run_next;
    logic access;
    logic wr_ok;
    logic mapped;
    logic protected_hit;
    logic ready_rise;

    // Address compare shared by write and read decoding
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction : hit

    // Bus decode; zero wait states, so pready is simply high
    assign access = psel && penable;
    assign mapped = hit(paddr, `OFS_INT_MASK) || hit(paddr, `OFS_INT_FLAG) ||
                    hit(paddr, `OFS_PWR_STATUS) || hit(paddr, `OFS_CTRL) ||
                    hit(paddr, `OFS_SLOW_CTRL);
    assign protected_hit = hit(paddr, `OFS_CTRL) || hit(paddr, `OFS_SLOW_CTRL);
    assign wr_ok = access && pwrite && !(write_protect && protected_hit);
    assign pready = 1'b1;
    assign pslverr = access && (!mapped || (pwrite && write_protect && protected_hit));

    // Control register; reserved bits are masked so they always read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= ctrl_t'(`CTRL_RESET);
        end else if (wr_ok && hit(paddr, `OFS_CTRL)) begin
            ctrl_reg <= ctrl_t'(pwdata[15:0] & `CTRL_WMASK);
        end
    end

    // Slow crystal register is storage only; the lock bit holds it until reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_ctrl_reg <= `SLOW_RESET;
        end else if (wr_ok && hit(paddr, `OFS_SLOW_CTRL) && !slow_ctrl_reg[`SLOW_LOCK_BIT]) begin
            slow_ctrl_reg <= pwdata[15:0] & `SLOW_WMASK;
        end
    end

    // Interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_reg <= 1'b0;
        end else if (wr_ok && hit(paddr, `OFS_INT_MASK)) begin
            int_mask_reg <= pwdata[`READY_BIT];
        end
    end

    // Run gating: enable, then standby, then request; registered to avoid glitches
    always_comb begin
        run_next = ctrl_reg.enable;
        if (standby && !ctrl_reg.run_in_standby) begin
            run_next = 1'b0;
        end else if (ctrl_reg.run_on_request && !clock_request) begin
            run_next = 1'b0;
        end
    end

    // Analog enable from a flop, so request or standby glitches never reach the amplifier
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= 1'b0;
        end else begin
            run_reg <= run_next;
        end
    end

    // Gain applied to the amplifier freezes while automatic control is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_reg <= 3'h0;
        end else if (!ctrl_reg.auto_amplitude_control) begin
            gain_reg <= ctrl_reg.gain;
        end
    end

    // Sequencer follows the gating decision, so ready falls in the same edge as the run output
    osc_start_delay_select_seq #(
        .CNT_W(CNT_W)
    ) u_start_delay_select (
        .pclk(pclk),
        .presetn(presetn),
        .run(run_next),
        .slow_tick(slow_osc_tick),
        .osc_tick(crystal_osc_tick),
        .delay_sel(ctrl_reg.start_delay_select),
        .ready(ready)
    );

    // Ready edge detect for the sticky flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q_reg <= 1'b0;
        end else begin
            ready_q_reg <= ready;
        end
    end

    assign ready_rise = ready && !ready_q_reg;

    // Sticky flag; a new rise in the clearing cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_flag_reg <= 1'b0;
        end else if (ready_rise) begin
            int_flag_reg <= 1'b1;
        end else if (wr_ok && hit(paddr, `OFS_INT_FLAG) && pwdata[`READY_BIT]) begin
            int_flag_reg <= 1'b0;
        end
    end

    // Read data captured in the setup phase, steady through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
        end else if (psel && !penable) begin
            prdata_reg <= 32'h0;
            if (hit(paddr, `OFS_CTRL)) begin
                prdata_reg <= {16'h0, ctrl_reg};
            end else if (hit(paddr, `OFS_SLOW_CTRL)) begin
                prdata_reg <= {16'h0, slow_ctrl_reg};
            end else if (hit(paddr, `OFS_PWR_STATUS)) begin
                prdata_reg <= {31'h0, ready};
            end else if (hit(paddr, `OFS_INT_FLAG)) begin
                prdata_reg <= {31'h0, int_flag_reg};
            end else if (hit(paddr, `OFS_INT_MASK)) begin
                prdata_reg <= {31'h0, int_mask_reg};
            end
        end
    end

    // Outputs
    assign prdata = prdata_reg;
    assign crystal_osc_run = run_reg;
    assign crystal_osc_ready = ready;
    assign crystal_select = ctrl_reg.crystal_select;
    assign output_pad_free = !ctrl_reg.crystal_select;
    assign auto_amplitude_control = ctrl_reg.auto_amplitude_control;
    assign osc_gain = gain_reg;
    assign slow_crystal_osc_ctrl = slow_ctrl_reg;
    assign irq = int_flag_reg && int_mask_reg;

    // Checks on gating, ready, gain, the flag and reserved bits
    a_ready_needs_run: assert property (@(posedge pclk) disable iff (!presetn)
        crystal_osc_ready |-> crystal_osc_run)
        else $error("ready while oscillator stopped");

    a_stop_clears: assert property (@(posedge pclk) disable iff (!presetn)
        !run_reg |=> !crystal_osc_ready)
        else $error("ready survived an oscillator stop");

    a_standby_off: assert property (@(posedge pclk) disable iff (!presetn)
        (standby && !ctrl_reg.run_in_standby) |=> !crystal_osc_run)
        else $error("oscillator ran in standby without permission");

    a_request_gate: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_reg.run_on_request && !clock_request) |=> !crystal_osc_run)
        else $error("oscillator ran with no clock request");

    a_continuous: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_reg.enable && !ctrl_reg.run_on_request && (!standby || ctrl_reg.run_in_standby))
        |=> crystal_osc_run)
        else $error("enabled oscillator not running continuously");

    a_disable_off: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_reg.enable |=> !crystal_osc_run)
        else $error("disabled oscillator running");

    a_gain_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg.auto_amplitude_control |=> $stable(osc_gain))
        else $error("gain changed under automatic control");

    a_flag_on_rise: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(crystal_osc_ready) |=> int_flag_reg ##0 (irq == int_mask_reg))
        else $error("ready rise did not set the flag");

    a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg.rsvd_5_3 == 3'h0 && !ctrl_reg.rsvd_0)
        else $error("reserved control bits not zero");

    // Checks on bus access, the mask, gain, pads, the flag, ready and the run decision
    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ok && hit(paddr, `OFS_INT_FLAG) && pwdata[`READY_BIT] && !ready_rise) |=> !int_flag_reg)
        else $error("flag survived a write of one");

    a_mask_hides: assert property (@(posedge pclk) disable iff (!presetn)
        !int_mask_reg |-> !irq)
        else $error("interrupt raised while masked");

    a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ok && hit(paddr, `OFS_INT_MASK)) |=> int_mask_reg == $past(pwdata[`READY_BIT]))
        else $error("mask write not applied");

    a_gain_follows: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_reg.auto_amplitude_control |=> osc_gain == $past(ctrl_reg.gain))
        else $error("gain field not applied with automatic control off");

    a_ready_drop: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(crystal_osc_run) |-> !crystal_osc_ready)
        else $error("ready still set after the oscillator stopped");

    a_ready_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (crystal_osc_ready && run_next) |=> crystal_osc_ready)
        else $error("ready lost while the oscillator kept running");

    a_pad_mux: assert property (@(posedge pclk) disable iff (!presetn)
        output_pad_free != crystal_select)
        else $error("pad use does not match crystal select");

    a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && hit(paddr, `OFS_PWR_STATUS)) |=> prdata == {31'h0, $past(crystal_osc_ready)})
        else $error("status read does not show ready");

    a_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && hit(paddr, `OFS_CTRL))
        |=> prdata[31:16] == 16'h0 && prdata[5:3] == 3'h0 && !prdata[0])
        else $error("reserved control bits read back nonzero");

    a_request_run: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_reg.enable && ctrl_reg.run_on_request && clock_request && (!standby || ctrl_reg.run_in_standby))
        |=> crystal_osc_run)
        else $error("requested oscillator not running");

    a_enable_start: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(crystal_osc_run) |-> $past(ctrl_reg.enable))
        else $error("oscillator started without its enable bit");

    c_ready_irq: cover property (@(posedge pclk) disable iff (!presetn)
        crystal_osc_ready && irq);

    c_request_stop: cover property (@(posedge pclk) disable iff (!presetn)
        crystal_osc_ready ##1 !crystal_osc_run);

    c_standby_run: cover property (@(posedge pclk) disable iff (!presetn)
        standby && crystal_osc_run);

    c_set_beats_clear: cover property (@(posedge pclk) disable iff (!presetn)
        ready_rise && wr_ok && hit(paddr, `OFS_INT_FLAG) && pwdata[`READY_BIT]);

endmodule : crystal_osc_ctrl

`default_nettype wire

// >>> core/crystal_osc_params.svh
`ifndef CRYSTAL_OSC_PARAMS_SVH
`define CRYSTAL_OSC_PARAMS_SVH

// Byte offsets on the register bus
`define OFS_INT_MASK 8'h04
`define OFS_INT_FLAG 8'h08
`define OFS_PWR_STATUS 8'h0c
`define OFS_CTRL 8'h10
`define OFS_SLOW_CTRL 8'h14

// Reset values and writable bit masks
`define CTRL_RESET 16'h0080
`define CTRL_WMASK 16'hffc6
`define SLOW_RESET 16'h0080
`define SLOW_WMASK 16'h17fe
`define SLOW_LOCK_BIT 12

// Bit of the ready flag in status, flag and mask registers
`define READY_BIT 0

// Oscillator cycles waited after the slow count
`define SYNC_CYCLES 2'd3

`endif

// >>> core/crystal_osc_pkg.sv
package crystal_osc_pkg;

    // Control register layout, bit 15 first
    typedef struct packed {
        logic [3:0] start_delay_select;
        logic auto_amplitude_control;
        logic [2:0] gain;
        logic run_on_request;
        logic run_in_standby;
        logic [2:0] rsvd_5_3;
        logic crystal_select;
        logic enable;
        logic rsvd_0;
    } ctrl_t;

    // Start-up sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COUNT = 2'b01,
        ST_SYNC = 2'b10,
        ST_READY = 2'b11
    } start_delay_select_state_t;

endpackage : crystal_osc_pkg

// >>> core/osc_start_delay_select_seq.sv
`timescale 1ns/1ns
`default_nettype none
`include "crystal_osc_params.svh"

module osc_start_delay_select_seq
    import crystal_osc_pkg::*;
#(
    parameter int CNT_W = 16
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic slow_tick,
    input wire logic osc_tick,
    input wire logic [3:0] delay_sel,
    output logic ready
);

    start_delay_select_state_t state_reg;
    logic [CNT_W-1:0] count_reg;
    logic [1:0] sync_reg;

    // Sequencer; dropping run returns to idle so a restart counts afresh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
        end else if (!run) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_reg <= ST_COUNT;
                end
                ST_COUNT: begin
                    if (slow_tick && count_reg == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                        state_reg <= ST_SYNC;
                    end
                end
                ST_SYNC: begin
                    if (osc_tick && sync_reg == `SYNC_CYCLES - 2'd1) begin
                        state_reg <= ST_READY;
                    end
                end
                ST_READY: begin
                    state_reg <= ST_READY;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Slow count: loaded with 2^n, decremented only by the always-on slow clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else if (state_reg == ST_IDLE) begin
            count_reg <= CNT_W'(1) << delay_sel;
        end else if (state_reg == ST_COUNT && slow_tick) begin
            count_reg <= count_reg - CNT_W'(1);
        end
    end

    // Oscillator-cycle synchronisation count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_reg <= 2'h0;
        end else if (state_reg != ST_SYNC) begin
            sync_reg <= 2'h0;
        end else if (osc_tick) begin
            sync_reg <= sync_reg + 2'h1;
        end
    end

    assign ready = (state_reg == ST_READY);

    a_count_load: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == ST_IDLE && run) |=> count_reg == (CNT_W'(1) << $past(delay_sel)))
        else $error("start count not loaded as a power of two");

    a_slow_only: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(state_reg) == ST_COUNT && state_reg == ST_COUNT && count_reg != $past(count_reg))
        |-> $past(slow_tick))
        else $error("start count moved without a slow clock tick");

    a_sync_three: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ready) |-> $past(osc_tick) && $past(sync_reg) == 2'h2 && $past(state_reg) == ST_SYNC)
        else $error("ready set without three oscillator cycles");

    c_long_start: cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == ST_IDLE && run && delay_sel == 4'hf);

endmodule : osc_start_delay_select_seq

`default_nettype wire

// >>> dv/osc_source_model.sv
`timescale 1ns/1ns
`default_nettype none

// Far side: always-on slow oscillator, the crystal and one clock-requesting peripheral
module osc_source_model #(
    parameter int SLOW_DIV = 8
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic want,
    output logic slow_tick,
    output logic osc_tick,
    output logic clock_request
);
    int div;

    // Slow oscillator runs free, whether or not the crystal is powered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 0;
            slow_tick <= 1'b0;
        end else begin
            div <= (div == SLOW_DIV - 1) ? 0 : div + 1;
            slow_tick <= (div == SLOW_DIV - 1);
        end
    end

    // Crystal ticks every other cycle and stops dead once power is removed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_tick <= 1'b0;
        end else begin
            osc_tick <= run && !osc_tick;
        end
    end

    // Request is registered, so it never changes in the edge that samples it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_request <= 1'b0;
        end else begin
            clock_request <= want;
        end
    end
endmodule : osc_source_model

`default_nettype wire

// >>> dv/crystal_osc_control_test.sv
`timescale 1ns/1ns
`default_nettype none

module crystal_oscillator_control_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] q;
    logic pready, pslverr, e;
    logic write_protect = 1'b0;
    logic standby = 1'b0;
    logic want = 1'b0;
    logic slow_tick, osc_tick, clock_request, run, xsel, pad_free, auto_ac, ready, irq;
    logic [2:0] gain;
    logic [15:0] slow_ctrl;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;

    always #20 pclk = ~pclk;

    crystal_osc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .write_protect(write_protect), .slow_osc_tick(slow_tick), .crystal_osc_tick(osc_tick),
        .clock_request(clock_request), .standby(standby), .crystal_osc_run(run), .crystal_select(xsel),
        .output_pad_free(pad_free), .auto_amplitude_control(auto_ac), .osc_gain(gain),
        .crystal_osc_ready(ready), .slow_crystal_osc_ctrl(slow_ctrl), .irq(irq));

    osc_source_model u_src (.pclk(pclk), .presetn(presetn), .run(run), .want(want),
        .slow_tick(slow_tick), .osc_tick(osc_tick), .clock_request(clock_request));

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // Runaway guard well beyond the few hundred cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        checks++;
        if (g !== x) begin
            err_total++;
            $display("BAD %0t %s got %h want %h", $time, m, g, x);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cyc

    // One APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        forever begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic io(input logic s, input logic w);
        @(posedge pclk);
        standby <= s;
        want <= w;
        cyc(3);
    endtask : io

    task automatic t_reset;
        apb(0, 8'h10, 32'h0);
        chk(q, 32'h0080, "ctrl reset");
        apb(0, 8'h14, 32'h0);
        chk(q, 32'h0080, "slow reset");
        apb(0, 8'h0c, 32'h0);
        chk(q, 32'h0, "status reset");
        chk(32'(pad_free), 32'h1, "pad free at reset");
        apb(0, 8'h20, 32'h0);
        chk(32'(e), 32'h1, "unmapped error");
    endtask : t_reset

    // Start-up length for delay codes 0..3, then ready, flag, irq and restart
    task automatic t_start_delay_select;
        int k;
        apb(1, 8'h04, 32'h1);
        for (int n = 0; n < 4; n++) begin
            apb(1, 8'h10, {16'h0, 4'(n), 12'h002});
            k = 0;
            while (ready !== 1'b1 && k < 300) begin
                cyc(1);
                k++;
            end
            chk(32'(k >= (1 << n) * 8 - 1 && k <= (1 << n) * 8 + 7), 32'h1, "start-up time");
            cyc(2);
            chk(32'(irq), 32'h1, "irq on ready");
            apb(0, 8'h0c, 32'h0);
            chk(q, 32'h1, "status ready");
            apb(1, 8'h08, 32'h1);
            cyc(1);
            chk(32'(irq), 32'h0, "irq cleared");
            apb(1, 8'h10, 32'h0);
            cyc(2);
            chk(32'(ready), 32'h0, "ready after stop");
        end
        apb(1, 8'h04, 32'h0);
        apb(1, 8'h10, 32'h0002);
        cyc(40);
        chk(32'(irq), 32'h0, "masked irq");
        apb(0, 8'h08, 32'h0);
        chk(q, 32'h1, "flag while masked");
        apb(1, 8'h08, 32'h1);
        apb(1, 8'h10, 32'h0);
    endtask : t_start_delay_select

    task automatic t_gate;
        apb(1, 8'h10, 32'h0082);
        io(0, 0);
        chk(32'(run), 32'h0, "no request");
        io(0, 1);
        chk(32'(run), 32'h1, "request");
        apb(1, 8'h10, 32'h0002);
        io(0, 0);
        chk(32'(run), 32'h1, "continuous");
        io(1, 0);
        chk(32'(run), 32'h0, "standby stop");
        apb(1, 8'h10, 32'h0042);
        io(1, 0);
        chk(32'(run), 32'h1, "standby run");
        apb(1, 8'h10, 32'h00c2);
        io(1, 0);
        chk(32'(run), 32'h0, "standby no request");
        io(1, 1);
        chk(32'(run), 32'h1, "standby request");
        apb(1, 8'h10, 32'h00c0);
        io(1, 1);
        chk(32'(run), 32'h0, "disabled");
        io(0, 0);
    endtask : t_gate

    task automatic t_gain;
        for (int g = 0; g < 5; g++) begin
            apb(1, 8'h10, {21'h0, 3'(g), 8'h00});
            cyc(1);
            chk(32'(gain), 32'(g), "gain applied");
            chk(32'(auto_ac), 32'h0, "auto off");
        end
        apb(1, 8'h10, 32'h0900);
        cyc(1);
        chk(32'(auto_ac), 32'h1, "auto on");
        chk(32'(gain), 32'h4, "gain held");
    endtask : t_gain

    task automatic t_fields;
        apb(1, 8'h10, 32'h0000fcc6);
        apb(0, 8'h10, 32'h0);
        chk(q, 32'hfcc6, "reserved read zero");
        chk(32'({xsel, pad_free}), 32'h2, "crystal pads");
        apb(1, 8'h10, 32'h0);
        write_protect <= 1'b1;
        apb(1, 8'h10, 32'h0004);
        chk(32'(e), 32'h1, "protected error");
        write_protect <= 1'b0;
        apb(0, 8'h10, 32'h0);
        chk(q, 32'h0, "protected unchanged");
        chk(32'({xsel, pad_free}), 32'h1, "external clock pads");
    endtask : t_fields

    // Lock bit freezes the slow register until reset; also gives a reset in mid-run
    task automatic t_lock;
        apb(1, 8'h14, 32'h07fe);
        apb(0, 8'h14, 32'h0);
        chk(q, 32'h07fe, "slow write");
        chk(32'(slow_ctrl), 32'h07fe, "slow output");
        apb(1, 8'h14, 32'h1000);
        apb(1, 8'h14, 32'h0080);
        apb(0, 8'h14, 32'h0);
        chk(q, 32'h1000, "slow locked");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h14, 32'h0);
        chk(q, 32'h0080, "slow after reset");
        chk(32'(slow_ctrl), 32'h0080, "slow output after reset");
        chk(32'({run, ready, irq, pad_free}), 32'h1, "outputs after reset");
    endtask : t_lock

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_start_delay_select();
        t_gate();
        t_gain();
        t_fields();
        t_lock();
        tally_and_finish();
    end
endmodule : crystal_oscillator_control_test

`default_nettype wire
